// ### hdl/rtc_calendar_alarm_output.sv
`timescale 1ns/1ns
// Clock/calendar with two alarms, shared interrupt/square pin and reset indicator
// Function
// - Count seconds through year from one-second tick
// - Month end honours short months and leap February
// - Hours in 24-hour or 12-hour with PM
// - Two programmable time-of-day alarms
// - Select bit 0: pin gives chosen square wave
// - Select bit 1: enabled alarm match pulls pin low
// - Power-up: select 1, both alarms disabled
// - Select and rate bits live in control register
// - Reference output low when either enable clear
// - Enabled reference output carries oscillator through synchroniser and output register
// - Set halt flag after oscillator stop period
// - Recovery delay only with oscillator enabled, running
// - Abandon serial transfer after interface timeout
// - Registers reached only through serial bus
// - Stop-detect period is 100 ms
// - Disable bit stops oscillator on backup supply
// - Debounced pushbutton also asserts reset indicator
module rtc_calendar_alarm_output
  import rtc_pkg::*;
#(
  parameter int TIMEOUT_CYC = TIMEOUT_CYC_DEF,
  parameter int HALT_CYC = HALT_CYC_DEF,
  parameter int RECOVER_CYC = RECOVER_CYC_DEF,
  parameter int RST_CYC = RST_CYC_DEF,
  parameter int DEBOUNCE_CYC = DEBOUNCE_CYC_DEF
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic osc_clk,
  input wire logic on_battery,
  input wire logic power_good,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic irq_or_square_out_n,
  output logic irq_or_square_oe,
  output logic ref_clock_out,
  output logic osc_enable,
  input wire logic reset_ind_in,
  output logic reset_ind_out,
  output logic reset_ind_oe
);
  typedef enum logic [1:0] {RS_HOLD, RS_WAIT, RS_IDLE} rst_state_t;

  logic osc_s1, osc_s2, osc_q; // Oscillator pin sampling
  logic bat_s1, bat_s2; // Supply source synchroniser
  logic pg_s1, pg_s2; // Supply good synchroniser
  logic rpin_s1, rpin_s2; // Reset pin synchroniser
  logic [7:0] reg_addr; // Serial register pointer
  logic wr_stb; // Register write strobe
  logic [7:0] wr_data;
  logic [7:0] rd_data;
  logic [7:0] tk [0:6]; // Time fields, BCD
  logic [7:0] next_tk [0:6];
  logic [7:0] alm [0:6]; // Alarm fields, BCD
  logic [7:0] next_alm [0:6];
  logic [7:0] ctrl, next_ctrl; // Control register
  logic [7:0] stat, next_stat; // Status register
  logic [14:0] div, next_div; // Oscillator edge divider
  logic tick, next_tick; // One-second pulse
  logic tick_q; // Compare one cycle after tick
  logic [22:0] stop_cnt, next_stop_cnt; // Cycles since last oscillator edge
  logic osc_edge, osc_dead;
  logic a1_hit, a2_hit;
  logic day_roll;
  logic [7:0] dim; // Days in current month
  logic sqw_bit;
  rst_state_t rs, next_rs;
  logic [23:0] rcnt, next_rcnt;
  logic pb, next_pb; // Wait started by pushbutton
  logic tk_wr, alm_wr;

  // BCD increment with wrap from hi back to lo
  function automatic logic [7:0] bcd_inc(input logic [7:0] v, input logic [7:0] hi,
                                         input logic [7:0] lo);
    if (v == hi) begin
      bcd_inc = lo;
    end else if (v[3:0] == 4'h9) begin
      bcd_inc = {4'(v[7:4] + 4'h1), 4'h0};
    end else begin
      bcd_inc = v + 8'h01;
    end
  endfunction

  // Last date of month, leap years by BCD year
  function automatic logic [7:0] month_days(input logic [7:0] m, input logic [7:0] y);
    logic leap;
    leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
    unique case (m[4:0])
      5'h02: month_days = leap ? 8'h29 : 8'h28;
      5'h04, 5'h06, 5'h09, 5'h11: month_days = 8'h30;
      default: month_days = 8'h31;
    endcase
  endfunction

  // Field match, bit 7 masks the field
  function automatic logic fmatch(input logic [7:0] a, input logic [7:0] t);
    fmatch = a[7] | (a[6:0] == t[6:0]);
  endfunction

  // Day-or-date match selected by bit 6
  function automatic logic dmatch(input logic [7:0] a, input logic [7:0] dy,
                                  input logic [7:0] dt);
    dmatch = a[7] | (a[6] ? (a[3:0] == dy[3:0]) : (a[5:0] == dt[5:0]));
  endfunction

  // Serial register port
  i2c_target #(
    .TIMEOUT_CYC(TIMEOUT_CYC)
  ) u_port (
    .mclk(mclk),
    .rstn(rstn),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .reg_addr(reg_addr),
    .wr_stb(wr_stb),
    .wr_data(wr_data),
    .rd_data(rd_data)
  );

  // Pin synchronisers
  always_ff @(posedge mclk) begin
    osc_s1 <= osc_clk;
    osc_s2 <= osc_s1;
    osc_q <= osc_s2;
    bat_s1 <= on_battery;
    bat_s2 <= bat_s1;
    pg_s1 <= power_good;
    pg_s2 <= pg_s1;
    rpin_s1 <= reset_ind_in;
    rpin_s2 <= rpin_s1;
  end

  assign osc_edge = osc_s2 & ~osc_q;
  assign osc_dead = (stop_cnt == 23'(HALT_CYC));
  assign tk_wr = wr_stb && reg_addr <= OFS_YEAR;
  assign alm_wr = wr_stb && reg_addr >= OFS_ALARM_FIRST && reg_addr <= OFS_ALARM_LAST;

  // Register read mux, unmapped reads zero
  always_comb begin
    if (reg_addr <= OFS_YEAR) begin
      rd_data = tk[reg_addr[2:0]];
    end else if (reg_addr <= OFS_ALARM_LAST) begin
      rd_data = alm[3'(reg_addr - OFS_ALARM_FIRST)];
    end else if (reg_addr == OFS_CONTROL) begin
      rd_data = ctrl;
    end else if (reg_addr == OFS_STATUS) begin
      rd_data = stat;
    end else begin
      rd_data = 8'h00;
    end
  end

  // Oscillator divider and stop detect
  always_comb begin
    next_div = div;
    next_tick = 1'b0;
    if (wr_stb && reg_addr == OFS_SECONDS) begin
      next_div = 15'h0000; // Seconds write restarts the second
    end else if (osc_edge) begin
      next_div = div + 15'h0001;
      next_tick = (div == OSC_DIV_MAX);
    end
    if (osc_edge) begin
      next_stop_cnt = 23'd0;
    end else if (!osc_dead) begin
      next_stop_cnt = stop_cnt + 23'd1;
    end else begin
      next_stop_cnt = stop_cnt;
    end
  end

  // Calendar rollover; bus writes win over the tick
  always_comb begin
    next_tk = tk;
    day_roll = 1'b0;
    dim = month_days(tk[5], tk[6]);
    if (tk_wr) begin
      next_tk[reg_addr[2:0]] = wr_data;
    end else if (tick && tk[0] == 8'h59) begin
      next_tk[0] = 8'h00;
      next_tk[1] = bcd_inc(tk[1], 8'h59, 8'h00);
      if (tk[1] == 8'h59) begin
        if (tk[2][HOUR_12H]) begin
          // 12-hour: 11 to 12 flips PM, 12 wraps to 01
          day_roll = tk[2][HOUR_PM] && tk[2][4:0] == 5'h11;
          next_tk[2] = ((tk[2] & 8'he0) ^ ((tk[2][4:0] == 5'h11) ? 8'h20 : 8'h00))
                     | bcd_inc(tk[2] & 8'h1f, 8'h12, 8'h01);
        end else begin
          day_roll = (tk[2] & 8'h3f) == 8'h23;
          next_tk[2] = (tk[2] & 8'hc0) | bcd_inc(tk[2] & 8'h3f, 8'h23, 8'h00);
        end
        if (day_roll) begin
          next_tk[3] = bcd_inc(tk[3], 8'h07, 8'h01);
          next_tk[4] = bcd_inc(tk[4], dim, 8'h01);
          if (tk[4] == dim) begin
            next_tk[5] = (tk[5] & 8'h80) | bcd_inc(tk[5] & 8'h1f, 8'h12, 8'h01);
            if (tk[5][4:0] == 5'h12) begin
              next_tk[6] = bcd_inc(tk[6], 8'h99, 8'h00);
              if (tk[6] == 8'h99) begin
                next_tk[5] = next_tk[5] ^ 8'h80; // Century toggles
              end
            end
          end
        end
      end
    end else if (tick) begin
      next_tk[0] = bcd_inc(tk[0], 8'h59, 8'h00);
    end
  end

  // Alarm compare, control and status
  always_comb begin
    next_alm = alm;
    if (alm_wr) begin
      next_alm[3'(reg_addr - OFS_ALARM_FIRST)] = wr_data;
    end
    a1_hit = tick_q && fmatch(alm[0], tk[0]) && fmatch(alm[1], tk[1])
           && fmatch(alm[2], tk[2]) && dmatch(alm[3], tk[3], tk[4]);
    a2_hit = tick_q && tk[0] == 8'h00 && fmatch(alm[4], tk[1])
           && fmatch(alm[5], tk[2]) && dmatch(alm[6], tk[3], tk[4]);
    next_ctrl = (wr_stb && reg_addr == OFS_CONTROL) ? wr_data : ctrl;
    next_stat = (wr_stb && reg_addr == OFS_STATUS) ? (wr_data & STA_WR_MASK) : stat;
    // Hardware set wins over a clearing write
    next_stat[STA_HALT] = next_stat[STA_HALT] | osc_dead;
    next_stat[STA_A1F] = next_stat[STA_A1F] | a1_hit;
    next_stat[STA_A2F] = next_stat[STA_A2F] | a2_hit;
    unique case ({ctrl[CTL_RATE_HI], ctrl[CTL_RATE_LO]})
      2'b00: sqw_bit = div[14];
      2'b01: sqw_bit = div[4];
      2'b10: sqw_bit = div[2];
      2'b11: sqw_bit = div[1];
    endcase
  end

  // Reset indicator sequencing
  always_comb begin
    next_rs = rs;
    next_rcnt = rcnt + 24'd1;
    next_pb = pb;
    if (!pg_s2) begin
      next_rs = RS_HOLD;
      next_rcnt = 24'd0;
      next_pb = 1'b0;
    end else begin
      unique case (rs)
        RS_HOLD: begin
          next_rcnt = 24'd0;
          // Recovery delay only while oscillator enabled and running
          next_rs = (ctrl[CTL_OSC_DIS] || osc_dead) ? RS_IDLE : RS_WAIT;
        end
        RS_WAIT: begin
          if (rcnt == (pb ? 24'(RST_CYC) : 24'(RECOVER_CYC))) begin
            next_rs = RS_IDLE;
            next_rcnt = 24'd0;
            next_pb = 1'b0;
          end
        end
        RS_IDLE: begin
          if (rpin_s2) begin
            next_rcnt = 24'd0;
          end else if (rcnt == 24'(DEBOUNCE_CYC)) begin
            next_rs = RS_WAIT;
            next_rcnt = 24'd0;
            next_pb = 1'b1;
          end
        end
      endcase
    end
  end

  // State and output registers
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      tk <= '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00};
      alm <= '{default: 8'h00};
      ctrl <= CONTROL_RST;
      stat <= STATUS_RST;
      div <= 15'h0000;
      tick <= 1'b0;
      tick_q <= 1'b0;
      stop_cnt <= 23'd0;
      rs <= RS_HOLD;
      rcnt <= 24'd0;
      pb <= 1'b0;
      irq_or_square_out_n <= 1'b0;
      irq_or_square_oe <= 1'b0;
      ref_clock_out <= 1'b0;
      osc_enable <= 1'b1;
      reset_ind_out <= 1'b0;
      reset_ind_oe <= 1'b1;
    end else begin
      tk <= next_tk;
      alm <= next_alm;
      ctrl <= next_ctrl;
      stat <= next_stat;
      div <= next_div;
      tick <= next_tick;
      tick_q <= tick;
      stop_cnt <= next_stop_cnt;
      rs <= next_rs;
      rcnt <= next_rcnt;
      pb <= next_pb;
      irq_or_square_out_n <= 1'b0;
      // Interrupt when selected, otherwise square wave
      irq_or_square_oe <= ctrl[CTL_OUT_SEL]
        ? ((stat[STA_A1F] & ctrl[CTL_A1_EN]) | (stat[STA_A2F] & ctrl[CTL_A2_EN]))
        : ~sqw_bit;
      ref_clock_out <= osc_s2 & stat[STA_REF_EN] & stat[STA_REF_BAT];
      osc_enable <= ~(bat_s2 & ctrl[CTL_OSC_DIS]);
      reset_ind_out <= 1'b0;
      reset_ind_oe <= (next_rs != RS_IDLE);
    end
  end
endmodule

// ### hdl/rtc_pkg.sv
// Shared constants for the clock/calendar block and its serial port
package rtc_pkg;
  localparam int CLK_HZ = 50_000_000; // mclk rate
  localparam int TIMEOUT_MS = 25; // serial transfer abandon time
  localparam int HALT_MS = 100; // oscillator stop-detect period
  localparam int RECOVER_MS = 125; // power-up recovery time
  localparam int RST_ACTIVE_MS = 250; // pushbutton reset pulse
  localparam int DEBOUNCE_MS = 250; // pushbutton debounce time
  localparam int TIMEOUT_CYC_DEF = CLK_HZ / 1000 * TIMEOUT_MS;
  localparam int HALT_CYC_DEF = CLK_HZ / 1000 * HALT_MS;
  localparam int RECOVER_CYC_DEF = CLK_HZ / 1000 * RECOVER_MS;
  localparam int RST_CYC_DEF = CLK_HZ / 1000 * RST_ACTIVE_MS;
  localparam int DEBOUNCE_CYC_DEF = CLK_HZ / 1000 * DEBOUNCE_MS;
  localparam logic [6:0] DEV_ADDR = 7'h51; // serial address, arbitrary
  // Register offsets
  localparam logic [7:0] OFS_SECONDS = 8'h00;
  localparam logic [7:0] OFS_YEAR = 8'h06;
  localparam logic [7:0] OFS_ALARM_FIRST = 8'h07;
  localparam logic [7:0] OFS_ALARM_LAST = 8'h0d;
  localparam logic [7:0] OFS_CONTROL = 8'h0e;
  localparam logic [7:0] OFS_STATUS = 8'h0f;
  // Control field positions
  localparam int CTL_OSC_DIS = 7;
  localparam int CTL_RATE_HI = 4;
  localparam int CTL_RATE_LO = 3;
  localparam int CTL_OUT_SEL = 2;
  localparam int CTL_A2_EN = 1;
  localparam int CTL_A1_EN = 0;
  // Status field positions
  localparam int STA_HALT = 7;
  localparam int STA_REF_BAT = 6;
  localparam int STA_REF_EN = 3;
  localparam int STA_A2F = 1;
  localparam int STA_A1F = 0;
  localparam logic [7:0] STA_WR_MASK = 8'hcb;
  // Hours field flags
  localparam int HOUR_12H = 6;
  localparam int HOUR_PM = 5;
  // Reset values and divider terminal count
  localparam logic [7:0] CONTROL_RST = 8'h1c;
  localparam logic [7:0] STATUS_RST = 8'hc8;
  localparam logic [55:0] TIME_RST = 56'h00_01_01_01_00_00_00;
  localparam logic [14:0] OSC_DIV_MAX = 15'h7fff;
endpackage

// ### hdl/i2c_target.sv
`timescale 1ns/1ns
// Serial register port: bit engine, register pointer and transfer timeout
module i2c_target
  import rtc_pkg::*;
#(
  parameter int TIMEOUT_CYC = TIMEOUT_CYC_DEF
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic [7:0] reg_addr,
  output logic wr_stb,
  output logic [7:0] wr_data,
  input wire logic [7:0] rd_data
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WDATA, ST_WACK, ST_RDATA, ST_RACK
  } bus_state_t;

  logic scl_s1, scl_s2, scl_q; // Clock pin synchroniser
  logic sda_s1, sda_s2, sda_q; // Data pin synchroniser
  bus_state_t state, next_state;
  logic [3:0] bcnt, next_bcnt; // Bit counter
  logic [7:0] shreg, next_shreg; // Shift register
  logic [7:0] next_ptr; // Register pointer
  logic ptr_pending, next_ptr_pending; // Next write byte is the pointer
  logic nack, next_nack; // Master refused more data
  logic next_oe;
  logic next_wr_stb;
  logic [7:0] next_wr_data;
  logic [20:0] tcnt, next_tcnt; // Idle-clock timer
  logic scl_rise, scl_fall, start, stop;

  // Wrap the pointer after the last register
  function automatic logic [7:0] ptr_inc(input logic [7:0] p);
    ptr_inc = (p == OFS_STATUS) ? 8'h00 : p + 8'h01;
  endfunction

  assign scl_rise = scl_s2 & ~scl_q;
  assign scl_fall = ~scl_s2 & scl_q;
  assign start = scl_s2 & scl_q & sda_q & ~sda_s2;
  assign stop = scl_s2 & scl_q & ~sda_q & sda_s2;

  // Pin synchronisers
  always_ff @(posedge mclk) begin
    scl_s1 <= scl_in;
    scl_s2 <= scl_s1;
    scl_q <= scl_s2;
    sda_s1 <= sda_in;
    sda_s2 <= sda_s1;
    sda_q <= sda_s2;
  end

  // Protocol next state
  always_comb begin
    next_state = state;
    next_bcnt = bcnt;
    next_shreg = shreg;
    next_ptr = wr_stb ? ptr_inc(reg_addr) : reg_addr; // Advance after a write
    next_ptr_pending = ptr_pending;
    next_nack = nack;
    next_oe = sda_oe;
    next_wr_stb = 1'b0;
    next_wr_data = wr_data;
    // Timer restarts on any clock edge, idles at zero
    next_tcnt = (state == ST_IDLE || scl_rise || scl_fall) ? 21'd0 : tcnt + 21'd1;
    if (start) begin
      next_state = ST_ADDR;
      next_bcnt = 4'd0;
      next_oe = 1'b0;
    end else if (stop || tcnt == 21'(TIMEOUT_CYC)) begin
      next_state = ST_IDLE;
      next_oe = 1'b0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          next_oe = 1'b0;
        end
        ST_ADDR, ST_WDATA: begin
          if (scl_rise) begin
            next_shreg = {shreg[6:0], sda_s2};
            next_bcnt = bcnt + 4'd1;
          end else if (scl_fall && bcnt == 4'd8) begin
            next_bcnt = 4'd0;
            if (state == ST_ADDR) begin
              // Answer only our own address
              if (shreg[7:1] == DEV_ADDR) begin
                next_state = ST_ADDR_ACK;
                next_oe = 1'b1;
                next_ptr_pending = ~shreg[0];
              end else begin
                next_state = ST_IDLE;
              end
            end else begin
              next_state = ST_WACK;
              next_oe = 1'b1;
              if (ptr_pending) begin
                next_ptr = shreg;
                next_ptr_pending = 1'b0;
              end else begin
                next_wr_stb = 1'b1;
                next_wr_data = shreg;
              end
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            if (shreg[0]) begin
              // Read: present first byte
              next_state = ST_RDATA;
              next_shreg = rd_data;
              next_oe = ~rd_data[7];
            end else begin
              next_state = ST_WDATA;
              next_oe = 1'b0;
            end
          end
        end
        ST_WACK: begin
          if (scl_fall) begin
            next_state = ST_WDATA;
            next_oe = 1'b0;
          end
        end
        ST_RDATA: begin
          if (scl_fall) begin
            if (bcnt == 4'd7) begin
              next_state = ST_RACK;
              next_bcnt = 4'd0;
              next_oe = 1'b0;
            end else begin
              next_bcnt = bcnt + 4'd1;
              next_shreg = {shreg[6:0], 1'b0};
              next_oe = ~shreg[6];
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            next_nack = sda_s2;
            if (!sda_s2) begin
              next_ptr = ptr_inc(reg_addr);
            end
          end else if (scl_fall) begin
            if (nack) begin
              next_state = ST_IDLE;
            end else begin
              next_state = ST_RDATA;
              next_shreg = rd_data;
              next_oe = ~rd_data[7];
            end
          end
        end
      endcase
    end
  end

  // Protocol registers
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      state <= ST_IDLE;
      bcnt <= 4'd0;
      shreg <= 8'h00;
      reg_addr <= 8'h00;
      ptr_pending <= 1'b0;
      nack <= 1'b0;
      sda_oe <= 1'b0;
      sda_out <= 1'b0;
      wr_stb <= 1'b0;
      wr_data <= 8'h00;
      tcnt <= 21'd0;
    end else begin
      state <= next_state;
      bcnt <= next_bcnt;
      shreg <= next_shreg;
      reg_addr <= next_ptr;
      ptr_pending <= next_ptr_pending;
      nack <= next_nack;
      sda_oe <= next_oe;
      sda_out <= 1'b0;
      wr_stb <= next_wr_stb;
      wr_data <= next_wr_data;
      tcnt <= next_tcnt;
    end
  end
endmodule

// ### dv/rtc_props.sv
// Port-level checker for the clock/calendar block
`timescale 1ns/1ns
module rtc_props #(
  parameter int TIMEOUT_CYC = 200
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic osc_clk,
  input wire logic on_battery,
  input wire logic power_good,
  input wire logic scl_in,
  input wire logic sda_oe,
  input wire logic irq_or_square_oe,
  input wire logic ref_clock_out,
  input wire logic osc_enable,
  input wire logic reset_ind_in,
  input wire logic reset_ind_oe
);
  int hold_cnt; // Cycles data is held low with the bus clock frozen
  logic scl_prev; // Bus clock one cycle back
  // Measure how long the data line is held while the clock stands still
  always_ff @(posedge mclk) begin
    scl_prev <= scl_in;
    if (!rstn || !sda_oe || scl_in != scl_prev) begin
      hold_cnt <= 0;
    end else begin
      hold_cnt <= hold_cnt + 1;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  reset_levels_a: assert property (disable iff (1'b0) !rstn |=>
    reset_ind_oe && osc_enable && !sda_oe && !irq_or_square_oe && !ref_clock_out)
    else $error("outputs not at reset levels");
  power_fail_a: assert property ((!power_good) [*5] |-> reset_ind_oe)
    else $error("reset indicator free during power fail");
  release_a: assert property ($fell(reset_ind_oe) |-> $past(power_good, 3))
    else $error("reset indicator released without main supply");
  button_a: assert property ($rose(reset_ind_oe) && $past(power_good, 2)
    && $past(power_good, 3) && $past(power_good, 4) |-> !$past(reset_ind_in, 3))
    else $error("reset indicator driven without a press");
  osc_main_a: assert property ((!on_battery) [*5] |-> osc_enable)
    else $error("oscillator stopped on main supply");
  osc_stop_a: assert property ($fell(osc_enable) |-> $past(on_battery, 2))
    else $error("oscillator stopped off backup supply");
  ref_follow_a: assert property ($rose(ref_clock_out)
    |-> $past(osc_clk, 2) || $past(osc_clk, 3))
    else $error("reference output rose without oscillator");
  bus_abandon_a: assert property (hold_cnt <= TIMEOUT_CYC + 8)
    else $error("data line held past transfer timeout");
  data_edge_a: assert property ($changed(sda_oe) |-> !$past(scl_in, 3))
    else $error("data line changed while bus clock high");
endmodule

bind rtc_calendar_alarm_output rtc_props #(.TIMEOUT_CYC(TIMEOUT_CYC)) props_i (.mclk, .rstn,
  .osc_clk, .on_battery, .power_good, .scl_in, .sda_oe, .irq_or_square_oe, .ref_clock_out,
  .osc_enable, .reset_ind_in, .reset_ind_oe);

// ### dv/i2c_master_model.sv
// Serial bus master model with open-drain data drive
`timescale 1ns/1ns
module i2c_master_model
  import rtc_pkg::*;
(
  input wire logic mclk,
  input wire logic sda,
  output logic scl,
  output logic sda_pull,
  output logic acked
);
  // Bus idle: clock high, data released
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
    acked = 1'b0;
  end
  // Waits on falling edges, away from the sampling edge
  task automatic tk(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // One bit, 16 cycles, far inside the interface timeout
  task automatic bit_io(input logic b, output logic s);
    sda_pull = ~b;
    tk(4);
    scl = 1'b1;
    tk(8);
    s = sda;
    scl = 1'b0;
    tk(4);
  endtask
  // Start or repeated start, leaves the clock low
  task automatic start();
    sda_pull = 1'b0;
    tk(4);
    scl = 1'b1;
    tk(8);
    sda_pull = 1'b1;
    tk(8);
    scl = 1'b0;
    tk(4);
  endtask
  // Stop, returns the bus to idle
  task automatic stop();
    sda_pull = 1'b1;
    tk(4);
    scl = 1'b1;
    tk(8);
    sda_pull = 1'b0;
    tk(8);
  endtask
  // Byte out, most significant bit first, then sample acknowledge
  task automatic put(input logic [7:0] dat);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(dat[i], s);
    bit_io(1'b1, s);
    acked = ~s;
  endtask
  // Byte in, answered with a not-acknowledge
  task automatic get(output logic [7:0] dat);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, dat[i]);
    bit_io(1'b1, s);
  endtask
  // Single-byte register write and read, each opened by a start and closed by a stop
  task automatic wr(input logic [7:0] ofs, input logic [7:0] dat);
    start();
    put({DEV_ADDR, 1'b0});
    put(ofs);
    put(dat);
    stop();
  endtask
  task automatic rd(input logic [7:0] ofs, output logic [7:0] dat);
    start();
    put({DEV_ADDR, 1'b0});
    put(ofs);
    start();
    put({DEV_ADDR, 1'b1});
    get(dat);
    stop();
  endtask
endmodule

// ### dv/tb_rtc_calendar_alarm_output.sv
// Self-checking bench for the clock/calendar block
`timescale 1ns/1ns
module tb_rtc_calendar_alarm_output;
  import rtc_pkg::*;
  logic mclk = 1'b0; // System clock
  logic rstn = 1'b0; // Reset, low active
  logic osc_clk = 1'b0; // Oscillator model
  logic osc_stop = 1'b0; // Freezes the oscillator
  logic on_battery = 1'b0; // Backup supply in use
  logic power_good = 1'b1; // Main supply present
  logic button = 1'b0; // Pushbutton pressed
  logic scl, sda_pull, acked, sda_oe, irq_or_square_oe, ref_clock_out, osc_enable, reset_ind_oe;
  logic sda_out, irq_or_square_out_n, reset_ind_out; // Open-drain data levels
  wire sda_in = ~(sda_pull | sda_oe); // Pulled-up data line
  wire reset_ind_in = ~(button | reset_ind_oe); // Pulled-up reset line
  int err_count = 0;
  int comparisons = 0;
  int cycles = 0;
  int n;
  int ex;
  logic [7:0] d;
  i2c_master_model m (.mclk, .sda(sda_in), .scl, .sda_pull, .acked);
  rtc_calendar_alarm_output #(.TIMEOUT_CYC(200), .HALT_CYC(2000), .RECOVER_CYC(100),
    .RST_CYC(100), .DEBOUNCE_CYC(50)) DUT (.mclk, .rstn, .osc_clk, .on_battery,
    .power_good, .scl_in(scl), .sda_in, .sda_out, .sda_oe, .irq_or_square_out_n,
    .irq_or_square_oe, .ref_clock_out, .osc_enable, .reset_ind_in, .reset_ind_out,
    .reset_ind_oe);
  always #10 mclk = ~mclk;
  // Oscillator, 160 ns period, offset from the system clock
  initial begin
    #3;
    forever begin
      #80;
      if (osc_enable && !osc_stop) osc_clk = ~osc_clk;
    end
  end
  // Cuts a hung run short
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 60000) begin
      err_count++;
      finish_test();
    end
  end
  task automatic finish_test();
    if (err_count == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic chk_n(input string nm, input int lo, input int hi, input int got);
    comparisons++;
    if (got < lo || got > hi) begin
      err_count++;
      $display("unexpected %s expected %0d..%0d seen %0d", nm, lo, hi, got);
    end
  endtask
  // Register read and compare
  task automatic rc(input logic [7:0] ofs, input logic [7:0] exp, input string nm);
    logic [7:0] v;
    m.rd(ofs, v);
    chk(nm, exp, v);
  endtask
  // Rising edges on the reference or shared pin over 1024 cycles
  task automatic edges(input logic pick, output int cnt);
    logic prev, cur;
    cnt = 0;
    prev = pick ? ref_clock_out : irq_or_square_oe;
    repeat (1024) begin
      @(negedge mclk);
      cur = pick ? ref_clock_out : irq_or_square_oe;
      if (cur === 1'b1 && prev === 1'b0) cnt++;
      prev = cur;
    end
  endtask
  // Main supply dip, then indicator sampled after a delay
  task automatic pfail(input int t, input logic [7:0] exp);
    power_good = 1'b0;
    m.tk(10);
    power_good = 1'b1;
    m.tk(t);
    chk("reset_ind_oe", exp, {7'h0, reset_ind_oe});
  endtask
  // Main sequence
  initial begin
    repeat (6) @(negedge mclk);
    rstn = 1'b1;
    m.tk(3);
    rc(OFS_CONTROL, CONTROL_RST, "control");
    chk("ack", 8'h01, {7'h0, acked});
    rc(OFS_STATUS, STATUS_RST, "status");
    for (int i = 0; i < 7; i++) rc(8'(i), TIME_RST[8*i +: 8], "time");
    m.wr(8'h02, 8'h72);
    rc(8'h02, 8'h72, "hour 12h");
    m.wr(OFS_ALARM_FIRST, 8'h45);
    rc(OFS_ALARM_FIRST, 8'h45, "alarm");
    rc(8'h20, 8'h00, "unmapped");
    edges(1'b1, n);
    chk_n("ref edges", 127, 129, n);
    m.wr(OFS_STATUS, 8'h08);
    edges(1'b1, n);
    chk_n("ref off", 0, 0, n);
    m.wr(OFS_STATUS, 8'h40);
    edges(1'b1, n);
    chk_n("ref off", 0, 0, n);
    m.wr(OFS_STATUS, 8'h48);
    rc(OFS_STATUS, 8'h48, "status");
    osc_stop = 1'b1;
    m.tk(2100);
    osc_stop = 1'b0;
    rc(OFS_STATUS, 8'hc8, "halt flag");
    for (int r = 0; r < 4; r++) begin
      m.wr(OFS_CONTROL, 8'(r << 3));
      edges(1'b0, n);
      ex = (r == 0) ? 0 : 128 / (r == 1 ? 32 : r == 2 ? 8 : 4);
      chk_n("square", (ex > 0) ? ex - 1 : 0, ex + 1, n);
    end
    m.wr(OFS_CONTROL, 8'h07);
    edges(1'b0, n);
    chk_n("irq idle", 0, 0, n);
    on_battery = 1'b1;
    m.wr(OFS_CONTROL, 8'h84);
    m.tk(5);
    chk("osc_enable", 8'h00, {7'h0, osc_enable});
    on_battery = 1'b0;
    m.tk(5);
    chk("osc_enable", 8'h01, {7'h0, osc_enable});
    pfail(8, 8'h00);
    m.wr(OFS_CONTROL, 8'h04);
    pfail(20, 8'h01);
    m.tk(110);
    chk("reset_ind_oe", 8'h00, {7'h0, reset_ind_oe});
    button = 1'b1;
    m.tk(60);
    chk("reset_ind_oe", 8'h01, {7'h0, reset_ind_oe});
    button = 1'b0;
    m.tk(120);
    chk("reset_ind_oe", 8'h00, {7'h0, reset_ind_oe});
    m.start();
    m.put({DEV_ADDR, 1'b0});
    m.put(OFS_CONTROL);
    m.start();
    m.put({DEV_ADDR, 1'b1});
    m.tk(4);
    chk("sda_oe", 8'h01, {7'h0, sda_oe});
    m.tk(250);
    chk("sda_oe", 8'h00, {7'h0, sda_oe});
    m.stop();
    rc(OFS_CONTROL, 8'h04, "control");
    chk("sda_out", 8'h00, {7'h0, sda_out});
    chk("irq_or_square_out_n", 8'h00, {7'h0, irq_or_square_out_n});
    chk("reset_ind_out", 8'h00, {7'h0, reset_ind_out});
    finish_test();
  end
endmodule
